//--- hw/sdcmd_pkg.sv
/*
 * Constants, state codes and helper functions of the card command path.
 * Assumes a 32-bit AXI4-Lite register window with byte addresses in the low eight bits.
 */
package sdcmd_pkg;
    // register byte offsets
    localparam logic [7:0]  OFS_CMD      = 8'h00;
    localparam logic [7:0]  OFS_ARG      = 8'h04;
    localparam logic [7:0]  OFS_TMO      = 8'h08;
    localparam logic [7:0]  OFS_CTRL     = 8'h0C;
    localparam logic [7:0]  OFS_CLKSET   = 8'h10;
    localparam logic [7:0]  OFS_CLKACT   = 8'h14;
    localparam logic [7:0]  OFS_RAW      = 8'h18;
    localparam logic [7:0]  OFS_REPLY0   = 8'h20;
    localparam logic [7:0]  OFS_REPLY1   = 8'h24;
    localparam logic [7:0]  OFS_REPLY2   = 8'h28;
    localparam logic [7:0]  OFS_REPLY3   = 8'h2C;
    // command register fields
    localparam int          CMD_IDX_LSB  = 0;
    localparam int          CMD_RESP_EXP = 6;
    localparam int          CMD_RESP_LNG = 7;
    localparam int          CMD_CHK_CRC  = 8;
    localparam int          CMD_WAIT_PRV = 13;
    localparam int          CMD_SEND_INI = 15;
    localparam int          CMD_CLK_ONLY = 21;
    localparam int          CMD_CCS_EXP  = 23;
    localparam int          CMD_START    = 31;
    // control register fields
    localparam int          CTRL_IRQ_RSP = 0;
    localparam int          CTRL_CCSD    = 1;
    localparam int          CTRL_AUTO_CS = 2;
    // raw status fields
    localparam int          RAW_RESP_ERR = 1;
    localparam int          RAW_CMD_DONE = 2;
    localparam int          RAW_DTO      = 3;
    localparam int          RAW_RCRC     = 6;
    localparam int          RAW_RTO      = 8;
    localparam int          RAW_ACD      = 14;
    // clock setting fields
    localparam int          CLK_EN       = 0;
    localparam int          CLK_DIV_LSB  = 8;
    localparam int          CLK_SRC_LSB  = 16;
    // reset values and bus response codes
    localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
    localparam logic [31:0] RST_TMO      = 32'h0000_0040;
    localparam logic [1:0]  AXI_OKAY     = 2'h0;
    localparam logic [1:0]  AXI_SLVERR   = 2'h2;
    // frame timing in card clock cycles, CRC-7 polynomial and fixed command fields
    localparam logic [7:0]  INIT_CYCLES  = 8'h50;
    localparam logic [7:0]  INIT_LAST    = INIT_CYCLES - 8'h01;
    localparam logic [7:0]  GAP_CYCLES   = 8'h08;
    localparam logic [7:0]  GAP_LAST     = GAP_CYCLES - 8'h01;
    localparam logic [7:0]  CCSD_WAIT    = 8'h08;
    localparam logic [7:0]  CCSD_LAST    = 8'h04;
    localparam logic [7:0]  HDR_BITS     = 8'h28;
    localparam logic [7:0]  FRAME_LAST   = 8'h2F;
    localparam logic [7:0]  LONG_LAST    = 8'h87;
    localparam logic [7:0]  LONG_CRC_LO  = 8'h08;
    localparam logic [7:0]  LONG_CRC_HI  = 8'h80;
    localparam logic [6:0]  CRC7_POLY    = 7'h09;
    localparam logic [5:0]  STOP_INDEX   = 6'h0C;
    localparam logic [5:0]  IRQ_INDEX    = 6'h28;
    localparam logic [31:0] IRQ_ARG      = 32'h0000_0000;
    localparam logic [4:0]  CCSD_PATTERN = 5'h01;

    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_INIT = 9'h002,
        ST_SEND = 9'h004,
        ST_WRSP = 9'h008,
        ST_RECV = 9'h010,
        ST_CCS  = 9'h020,
        ST_CCSD = 9'h040,
        ST_PBIT = 9'h080,
        ST_GAP  = 9'h100
    } sdcmd_state_type;

    function automatic logic [6:0] sdcmd_crc7(input logic [6:0] crc, input logic din);
        logic fb;
        fb = din ^ crc[6];
        return {crc[5:0], 1'b0} ^ (fb ? CRC7_POLY : 7'h00);
    endfunction

    function automatic logic [31:0] sdcmd_merge(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) res[8*i +: 8] = new_v[8*i +: 8];
        end
        return res;
    endfunction
endpackage

//--- hw/sdcmd_command_path.sv
/*
 * Card command path: loads commands from the register window, sends framed commands
 * with CRC-7 on the card command line, receives and checks responses, handles CE-ATA
 * completion signalling. Assumes ref_clk_in is the card clock and the command line
 * reads 1 when nobody drives it; the data path reports busy, open-ended and done.
 */
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
module sdcmd_command_path (
    // clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    // axi4-lite write
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    // card command line
    input  wire logic        card_cmd_in,
    output logic             card_cmd_out,
    output logic             card_cmd_oe_n_out,
    // data path status
    input  wire logic        data_busy_in,
    input  wire logic        data_open_ended_in,
    input  wire logic        data_done_in,
    input  wire logic        data_auto_stop_in,
    // clock control settings
    output logic             clk_enable_out,
    output logic [7:0]       clk_divider_out,
    output logic [1:0]       clk_source_out
);
    import sdcmd_pkg::*;

    sdcmd_state_type state;
    logic [31:0]     cmd_reg;
    logic [31:0]     arg_reg;
    logic [31:0]     tmo_reg;
    logic [31:0]     ctrl_reg;
    logic [31:0]     clk_set;
    logic [31:0]     clk_act;
    logic [31:0]     raw_reg;
    logic [31:0]     reply_word_zero;
    logic [31:0]     reply_word_one;
    logic [31:0]     reply_word_two;
    logic [31:0]     reply_word_three;
    logic [31:0]     ev_set;
    logic [7:0]      cnt;
    logic [39:0]     tx_hdr;
    logic [6:0]      crc;
    logic [135:0]    rx_sh;
    logic [5:0]      cur_idx;
    logic [7:0]      cur_tmo;
    logic            cur_resp;
    logic            cur_long;
    logic            cur_chk;
    logic            cur_ccs;
    logic            cur_auto;
    logic            stop_pend;
    logic            aw_hold;
    logic [7:0]      aw_addr;
    logic            w_hold;
    logic [31:0]     w_data;
    logic [3:0]      w_strb;

    // load and exit conditions
    wire in_idle   = (state == ST_IDLE);
    wire data_free = !cmd_reg[CMD_WAIT_PRV] || !data_busy_in || data_open_ended_in;
    wire take_stop = in_idle && stop_pend;
    wire take_sw   = in_idle && !stop_pend && cmd_reg[CMD_START] && data_free;
    wire take_cmd  = take_sw && !cmd_reg[CMD_CLK_ONLY];
    wire take_clk  = take_sw && cmd_reg[CMD_CLK_ONLY];
    wire take_irq  = (state == ST_WRSP) && ctrl_reg[CTRL_IRQ_RSP];
    wire ccs_seen  = (state == ST_CCS) && !card_cmd_in;
    wire take_ccsd = (state == ST_CCS) && ctrl_reg[CTRL_CCSD] && !ccs_seen
                     && (cnt == CCSD_WAIT);
    wire ccsd_done = (state == ST_CCSD) && (cnt == CCSD_LAST);
    wire set_stop  = (data_done_in && data_auto_stop_in)
                     || (ccsd_done && ctrl_reg[CTRL_AUTO_CS]);

    // response checks on the complete received frame
    wire [135:0] rx_fin   = {rx_sh[134:0], card_cmd_in};
    wire [7:0]   rx_last  = cur_long ? LONG_LAST : FRAME_LAST;
    wire         rx_crc_on = cur_long ? (cnt >= LONG_CRC_LO && cnt < LONG_CRC_HI)
                                      : (cnt < HDR_BITS);
    wire         bad_tx   = cur_long ? rx_fin[134] : rx_fin[46];
    wire         bad_idx  = !cur_long && cur_chk && (rx_fin[45:40] != cur_idx);
    wire         resp_err = bad_tx || !rx_fin[0] || bad_idx;
    wire         crc_err  = cur_chk && (crc != rx_fin[7:1]);

    // bus decode
    wire         wr_fire  = aw_hold && w_hold && !s_axi_bvalid_out;
    wire         wr_cmd   = wr_fire && (aw_addr == OFS_CMD);
    wire         wr_arg   = wr_fire && (aw_addr == OFS_ARG);
    wire         wr_tmo   = wr_fire && (aw_addr == OFS_TMO);
    wire         wr_ctrl  = wr_fire && (aw_addr == OFS_CTRL);
    wire         wr_clk   = wr_fire && (aw_addr == OFS_CLKSET);
    wire         wr_raw   = wr_fire && (aw_addr == OFS_RAW);
    wire         wr_ro    = (aw_addr == OFS_CLKACT) || (aw_addr == OFS_REPLY0)
                            || (aw_addr == OFS_REPLY1) || (aw_addr == OFS_REPLY2)
                            || (aw_addr == OFS_REPLY3);
    wire         wr_hit   = wr_cmd || wr_arg || wr_tmo || wr_ctrl || wr_clk || wr_raw
                            || (wr_fire && wr_ro);
    wire [31:0]  raw_clr  = wr_raw ? sdcmd_merge(RST_ZERO, w_data, w_strb) : RST_ZERO;
    wire [7:0]   ra       = s_axi_araddr_in;
    wire         rd_hit   = (ra == OFS_CMD) || (ra == OFS_ARG) || (ra == OFS_TMO)
                            || (ra == OFS_CTRL) || (ra == OFS_CLKSET) || (ra == OFS_CLKACT)
                            || (ra == OFS_RAW) || (ra == OFS_REPLY0) || (ra == OFS_REPLY1)
                            || (ra == OFS_REPLY2) || (ra == OFS_REPLY3);
    wire [31:0]  rd_val   = (ra == OFS_CMD)    ? cmd_reg :
                            (ra == OFS_ARG)    ? arg_reg :
                            (ra == OFS_TMO)    ? tmo_reg :
                            (ra == OFS_CTRL)   ? ctrl_reg :
                            (ra == OFS_CLKSET) ? clk_set :
                            (ra == OFS_CLKACT) ? clk_act :
                            (ra == OFS_RAW)    ? raw_reg :
                            (ra == OFS_REPLY0) ? reply_word_zero :
                            (ra == OFS_REPLY1) ? reply_word_one :
                            (ra == OFS_REPLY2) ? reply_word_two :
                            (ra == OFS_REPLY3) ? reply_word_three : RST_ZERO;

    assign s_axi_awready_out = !aw_hold && !s_axi_bvalid_out;
    assign s_axi_wready_out  = !w_hold && !s_axi_bvalid_out;
    assign s_axi_arready_out = !s_axi_rvalid_out;
    assign clk_enable_out    = clk_act[CLK_EN];
    assign clk_divider_out   = clk_act[CLK_DIV_LSB +: 8];
    assign clk_source_out    = clk_act[CLK_SRC_LSB +: 2];

    // axi4-lite handshakes
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            aw_hold          <= 1'b0;
            aw_addr          <= 8'h00;
            w_hold           <= 1'b0;
            w_data           <= RST_ZERO;
            w_strb           <= 4'h0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= AXI_OKAY;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out  <= RST_ZERO;
            s_axi_rresp_out  <= AXI_OKAY;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata_in;
                w_strb <= s_axi_wstrb_in;
            end
            if (wr_fire) begin
                aw_hold          <= 1'b0;
                w_hold           <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= wr_hit ? AXI_OKAY : AXI_SLVERR;
            end else if (s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
            if (s_axi_arvalid_in && s_axi_arready_out) begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out  <= rd_val;
                s_axi_rresp_out  <= rd_hit ? AXI_OKAY : AXI_SLVERR;
            end else if (s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end

    // software registers; hardware events beat a same-cycle clear
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cmd_reg  <= RST_ZERO;
            arg_reg  <= RST_ZERO;
            tmo_reg  <= RST_TMO;
            ctrl_reg <= RST_ZERO;
            clk_set  <= RST_ZERO;
            clk_act  <= RST_ZERO;
            raw_reg  <= RST_ZERO;
        end else begin
            if (wr_cmd) cmd_reg <= sdcmd_merge(cmd_reg, w_data, w_strb);
            else if (take_sw) cmd_reg[CMD_START] <= 1'b0;
            if (wr_arg) arg_reg <= sdcmd_merge(arg_reg, w_data, w_strb);
            if (wr_tmo) tmo_reg <= sdcmd_merge(tmo_reg, w_data, w_strb);
            if (wr_clk) clk_set <= sdcmd_merge(clk_set, w_data, w_strb);
            if (take_clk) clk_act <= clk_set;
            if (wr_ctrl) begin
                ctrl_reg <= sdcmd_merge(ctrl_reg, w_data, w_strb);
            end else begin
                if (take_irq) ctrl_reg[CTRL_IRQ_RSP] <= 1'b0;
                if (ccsd_done) ctrl_reg[CTRL_CCSD] <= 1'b0;
            end
            raw_reg <= (raw_reg & ~raw_clr) | ev_set;
        end
    end

    // command sequencer and command line driver
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state             <= ST_IDLE;
            cnt               <= 8'h00;
            tx_hdr            <= 40'h00_0000_0000;
            crc               <= 7'h00;
            rx_sh             <= '0;
            cur_idx           <= 6'h00;
            cur_tmo           <= 8'h00;
            cur_resp          <= 1'b0;
            cur_long          <= 1'b0;
            cur_chk           <= 1'b0;
            cur_ccs           <= 1'b0;
            cur_auto          <= 1'b0;
            stop_pend         <= 1'b0;
            ev_set            <= RST_ZERO;
            reply_word_zero   <= RST_ZERO;
            reply_word_one    <= RST_ZERO;
            reply_word_two    <= RST_ZERO;
            reply_word_three  <= RST_ZERO;
            card_cmd_out      <= 1'b1;
            card_cmd_oe_n_out <= 1'b1;
        end else begin
            ev_set            <= RST_ZERO;
            card_cmd_out      <= 1'b1;
            card_cmd_oe_n_out <= 1'b1;
            if (set_stop) stop_pend <= 1'b1;
            else if (take_stop) stop_pend <= 1'b0;
            case (state)
                ST_IDLE: begin
                    cnt <= 8'h00;
                    crc <= 7'h00;
                    if (take_stop) begin
                        tx_hdr   <= {2'h1, STOP_INDEX, RST_ZERO};
                        cur_idx  <= STOP_INDEX;
                        cur_tmo  <= tmo_reg[7:0];
                        cur_resp <= 1'b1;
                        cur_long <= 1'b0;
                        cur_chk  <= 1'b1;
                        cur_ccs  <= 1'b0;
                        cur_auto <= 1'b1;
                        state    <= ST_SEND;
                    end else if (take_cmd) begin
                        tx_hdr   <= {2'h1, cmd_reg[CMD_IDX_LSB +: 6], arg_reg};
                        cur_idx  <= cmd_reg[CMD_IDX_LSB +: 6];
                        cur_tmo  <= tmo_reg[7:0];
                        cur_resp <= cmd_reg[CMD_RESP_EXP];
                        cur_long <= cmd_reg[CMD_RESP_LNG];
                        cur_chk  <= cmd_reg[CMD_CHK_CRC];
                        cur_ccs  <= cmd_reg[CMD_CCS_EXP];
                        cur_auto <= 1'b0;
                        state    <= cmd_reg[CMD_SEND_INI] ? ST_INIT : ST_SEND;
                    end
                end
                ST_INIT: begin
                    card_cmd_oe_n_out <= 1'b0;
                    cnt <= cnt + 8'h01;
                    if (cnt == INIT_LAST) begin
                        cnt   <= 8'h00;
                        state <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    card_cmd_oe_n_out <= 1'b0;
                    cnt <= cnt + 8'h01;
                    if (cnt < HDR_BITS) begin
                        card_cmd_out <= tx_hdr[39];
                        tx_hdr       <= {tx_hdr[38:0], 1'b0};
                        crc          <= sdcmd_crc7(crc, tx_hdr[39]);
                    end else if (cnt < FRAME_LAST) begin
                        card_cmd_out <= crc[6];
                        crc          <= {crc[5:0], 1'b0};
                    end else begin
                        cnt   <= 8'h00;
                        state <= cur_resp ? ST_WRSP : ST_PBIT;
                    end
                end
                ST_WRSP: begin
                    cnt <= cnt + 8'h01;
                    crc <= 7'h00;
                    if (take_irq) begin
                        tx_hdr   <= {2'h0, IRQ_INDEX, IRQ_ARG};
                        cur_resp <= 1'b0;
                        cur_ccs  <= 1'b0;
                        cur_auto <= 1'b0;
                        cnt      <= 8'h00;
                        state    <= ST_SEND;
                    end else if (!card_cmd_in) begin
                        rx_sh <= '0;
                        cnt   <= 8'h01;
                        state <= ST_RECV;
                    end else if (cnt == cur_tmo) begin
                        ev_set[RAW_RTO]      <= 1'b1;
                        ev_set[RAW_CMD_DONE] <= 1'b1;
                        state                <= ST_PBIT;
                    end
                end
                ST_RECV: begin
                    cnt   <= cnt + 8'h01;
                    rx_sh <= rx_fin;
                    if (rx_crc_on) crc <= sdcmd_crc7(crc, card_cmd_in);
                    if (cnt == rx_last) begin
                        cnt                  <= 8'h00;
                        ev_set[RAW_RESP_ERR] <= resp_err;
                        ev_set[RAW_RCRC]     <= crc_err;
                        if (cur_auto) begin
                            reply_word_one  <= rx_fin[39:8];
                            ev_set[RAW_ACD] <= 1'b1;
                        end else begin
                            ev_set[RAW_CMD_DONE] <= 1'b1;
                            if (cur_long) begin
                                reply_word_three <= rx_fin[127:96];
                                reply_word_two   <= rx_fin[95:64];
                                reply_word_one   <= rx_fin[63:32];
                                reply_word_zero  <= rx_fin[31:0];
                            end else begin
                                reply_word_zero <= rx_fin[39:8];
                            end
                        end
                        state <= cur_ccs ? ST_CCS : ST_PBIT;
                    end
                end
                ST_CCS: begin
                    if (cnt != CCSD_WAIT) cnt <= cnt + 8'h01;
                    if (ccs_seen) begin
                        ev_set[RAW_DTO]      <= 1'b1;
                        ev_set[RAW_CMD_DONE] <= ctrl_reg[CTRL_CCSD];
                        state                <= ST_PBIT;
                    end else if (take_ccsd) begin
                        tx_hdr <= {CCSD_PATTERN, 35'h0_0000_0000};
                        cnt    <= 8'h00;
                        state  <= ST_CCSD;
                    end
                end
                ST_CCSD: begin
                    card_cmd_oe_n_out <= 1'b0;
                    card_cmd_out      <= tx_hdr[39];
                    tx_hdr            <= {tx_hdr[38:0], 1'b0};
                    cnt               <= cnt + 8'h01;
                    if (ccsd_done) begin
                        ev_set[RAW_CMD_DONE] <= 1'b1;
                        state                <= ST_PBIT;
                    end
                end
                ST_PBIT: begin
                    card_cmd_oe_n_out <= 1'b0;
                    card_cmd_out      <= 1'b1;
                    if (!cur_resp) ev_set[RAW_CMD_DONE] <= 1'b1;
                    cnt   <= 8'h00;
                    state <= ST_GAP;
                end
                ST_GAP: begin
                    cnt <= cnt + 8'h01;
                    if (cnt == GAP_LAST) state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

//--- dv/sdcmd_chk.sv
/* Checker of bus handshakes and line release of the command path.
   Bound to the top module; sees its ports only. */
`timescale 1ns/100ps
module sdcmd_chk (
    input wire logic ref_clk_in, rst_in, card_cmd_out, card_cmd_oe_n_out,
    input wire logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in,
    input wire logic s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    property p_bh; s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out; endproperty
    a_bh: assert property (p_bh) else $error("bvalid dropped");
    property p_rh; s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out; endproperty
    a_rh: assert property (p_rh) else $error("rvalid dropped");
    property p_ab; $rose(s_axi_rvalid_out) |-> $past(s_axi_arvalid_in); endproperty
    a_ab: assert property (p_ab) else $error("read answer without request");
    property p_wb; $rose(s_axi_bvalid_out) |-> !$past(s_axi_wready_out); endproperty
    a_wb: assert property (p_wb) else $error("bvalid without data");
    property p_bc; $rose(s_axi_bvalid_out) |-> !$past(s_axi_awready_out); endproperty
    a_bc: assert property (p_bc) else $error("bvalid without address");
    property p_rl; s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out; endproperty
    a_rl: assert property (p_rl) else $error("late read answer");
    property p_id; card_cmd_oe_n_out |-> card_cmd_out; endproperty
    a_id: assert property (p_id) else $error("released line not high");
    property p_gp; $rose(card_cmd_oe_n_out) |-> card_cmd_oe_n_out [*8]; endproperty
    a_gp: assert property (p_gp) else $error("gap too short");
    c_fr: cover property ($fell(card_cmd_oe_n_out));
    c_wr: cover property (s_axi_bvalid_out && s_axi_bready_in);
    c_rd: cover property (s_axi_rvalid_out && s_axi_rready_in);
endmodule
bind sdcmd_command_path sdcmd_chk u_chk (.*);

//--- dv/sdcmd_card.sv
/* Card model: checks host frames, answers short replies when enabled.
   Assumes a pulled-up line resolved outside; samples on falling edges. */
`timescale 1ns/100ps
module sdcmd_card (
    input  wire logic clk_in, line_in, reply_en_in,
    output logic      drv_n_out = 1'b1, dout_out = 1'b1,
    output int        bad_out = 0
);
    logic [47:0] sh;
    function automatic logic [6:0] crc(input logic [39:0] m);
        logic [6:0] q = 7'h00;
        for (int i = 39; i >= 0; i--) q = {q[5:0], 1'b0} ^ (m[i] ^ q[6] ? 7'h09 : 7'h00);
        return q;
    endfunction
    initial forever begin
        @(negedge clk_in iff line_in === 1'b0);
        sh = 48'h0;
        repeat (47) @(negedge clk_in) sh = {sh[46:0], line_in};
        if (!sh[46] || !sh[0] || crc(sh[47:8]) !== sh[7:1]) bad_out++;
        sh[47:8] = {2'b00, sh[45:40], 32'hA5C3_0F96};
        sh[7:0] = {crc(sh[47:8]), 1'b1};
        repeat (4) @(posedge clk_in);
        for (int i = 47; i >= 0 && reply_en_in; i--) @(posedge clk_in) {drv_n_out, dout_out} <= {1'b0, sh[i]};
        @(posedge clk_in) drv_n_out <= 1'b1;
    end
endmodule

//--- dv/sd_mmc_command_path_bench.sv
/* Bench of the card command path with the card model on its line.
   Assumes the card model and the bound checker are compiled with it. */
`timescale 1ns/100ps
module sd_mmc_command_path_bench;
    import sdcmd_pkg::*;
    logic ref_clk_in = '0, rst_in = '1, s_axi_awvalid_in = '0, s_axi_wvalid_in = '0, en = '0;
    logic s_axi_bready_in = '0, s_axi_arvalid_in = '0, s_axi_rready_in = '0, data_busy_in = '0;
    logic data_open_ended_in = '0, data_done_in = '0, data_auto_stop_in = '0;
    logic [7:0] s_axi_awaddr_in = '0, s_axi_araddr_in = '0;
    logic [31:0] s_axi_wdata_in = '0, v;
    logic [3:0] s_axi_wstrb_in = 4'hF;
    logic [1:0] rs;
    wire logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, drv_n;
    wire logic s_axi_rvalid_out, card_cmd_out, card_cmd_oe_n_out, clk_enable_out, cdo;
    wire logic [1:0] s_axi_bresp_out, s_axi_rresp_out, clk_source_out;
    wire logic [31:0] s_axi_rdata_out;
    wire logic [7:0] clk_divider_out;
    wire logic card_cmd_in = ~((~card_cmd_oe_n_out & ~card_cmd_out) | (~drv_n & ~cdo));
    int error_cnt = 0, n_compared = 0, cyc = 0, bad;
    sdcmd_command_path uut (.*);
    sdcmd_card card (.clk_in(ref_clk_in), .line_in(card_cmd_in), .reply_en_in(en),
        .drv_n_out(drv_n), .dout_out(cdo), .bad_out(bad));
    initial forever #2 ref_clk_in = ~ref_clk_in;
    task chk(input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value at %0t: %h, expected %h", $time, s, e);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic ta, tb;
        @(posedge ref_clk_in);
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} <= {a, a, d};
        if (w) {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
        else {s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
        do begin
            @(negedge ref_clk_in);
            ta = s_axi_awvalid_in & s_axi_awready_out | s_axi_arvalid_in & s_axi_arready_out;
            tb = w ? s_axi_bvalid_out : s_axi_rvalid_out;
            {rs, v} = {w ? s_axi_bresp_out : s_axi_rresp_out, s_axi_rdata_out};
            @(posedge ref_clk_in);
            if (ta) {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_arvalid_in} <= 3'h0;
        end while (!tb);
        {s_axi_bready_in, s_axi_rready_in} <= 2'h0;
    endtask
    task done(input logic [31:0] e);
        repeat (60) begin
            bus(0, OFS_RAW, 0);
            if ((v[RAW_CMD_DONE] | v[RAW_ACD]) === 1'b1) break;
        end
        chk(v, e);
        bus(1, OFS_RAW, v);
    endtask
    task t_clk;
        bus(1, OFS_CLKSET, 32'h0002_3401);
        bus(1, OFS_CMD, 32'h8020_0000);
        bus(0, OFS_CLKACT, 0);
        chk(v, 32'h0002_3401);
        chk({clk_source_out, clk_divider_out, clk_enable_out}, 11'h469);
        bus(0, OFS_CMD, 0);
        chk(v[31], 1'b0);
        bus(0, OFS_RAW, 0);
        chk(v, 32'h0);
        bus(0, 8'h1C, 0);
        chk(rs, AXI_SLVERR);
        bus(1, 8'h1C, 0);
        chk(rs, AXI_SLVERR);
    endtask
    task t_none;
        bus(1, OFS_CMD, 32'h8000_0005);
        done(32'h0000_0004);
    endtask
    task t_tmo;
        bus(1, OFS_CMD, 32'h8000_0042);
        done(32'h0000_0104);
    endtask
    task t_short;
        en <= 1'b1;
        bus(1, OFS_CMD, 32'h8000_0151);
        done(32'h0000_0004);
        bus(0, OFS_REPLY0, 0);
        chk(v, 32'hA5C3_0F96);
    endtask
    task t_wait;
        data_busy_in <= 1'b1;
        bus(1, OFS_CMD, 32'h8000_2005);
        repeat (20) @(posedge ref_clk_in);
        bus(0, OFS_CMD, 0);
        chk(v[31], 1'b1);
        data_busy_in <= 1'b0;
        done(32'h0000_0004);
    endtask
    task t_stop;
        {data_done_in, data_auto_stop_in} <= 2'h3;
        @(posedge ref_clk_in) data_done_in <= 1'b0;
        done(32'h0000_4000);
        bus(0, OFS_REPLY1, 0);
        chk(v, 32'hA5C3_0F96);
    endtask
    task tally_and_finish;
        $display("mismatches %0d of %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        t_clk;
        t_none;
        t_wait;
        t_tmo;
        t_short;
        t_stop;
        chk(bad, 0);
        tally_and_finish;
    end
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish;
        end
    end
endmodule
